// file: logic/ddpa_cfg.svh
`ifndef DDPA_CFG_SVH
`define DDPA_CFG_SVH

// Register indices; byte address is four times the index
`define DDPA_AUX_IDX 10'h0A2
`define DDPA_PTR_IDX 10'h0A4
`define DDPA_INC_IDX 10'h0A5
`define DDPA_DP0_IDX 10'h0A6
`define DDPA_DP1_IDX 10'h0A7

// Field positions in aux_control_one
`define DDPA_SEL_BIT 0
`define DDPA_ZERO_BIT 2
`define DDPA_FLAG_BIT 3
`define DDPA_BOOT_BIT 5

// Reset values
`define DDPA_SEL_RST 1'b0
`define DDPA_FLAG_RST 1'b0
`define DDPA_BOOT_RST 1'b0
`define DDPA_PTR_RST 16'h0000

// Boot memory window base
`define DDPA_BOOT_BASE 16'hF800

`endif

// file: logic/ddpa_pkg.sv
package ddpa_pkg;

    typedef enum logic [1:0]
    {
        INIT_SYNC1 = 2'b00,
        INIT_SYNC2 = 2'b01,
        INIT_LOAD = 2'b10,
        INIT_RUN = 2'b11
    } ddpa_init_type;

    typedef enum logic [2:0]
    {
        REG_NONE = 3'b000,
        REG_AUX = 3'b001,
        REG_PTR = 3'b010,
        REG_INC = 3'b011,
        REG_DP0 = 3'b100,
        REG_DP1 = 3'b101
    } ddpa_reg_type;

endpackage

// file: logic/ddpa_ptr_if.sv
interface ddpa_ptr_if;
    logic sel;
    logic load_en;
    logic inc_en;
    logic [15:0] load_val;
    logic [15:0] ptr [2];

    modport ctrl
    (
        output sel,
        output load_en,
        output inc_en,
        output load_val,
        input ptr
    );

    modport bank
    (
        input sel,
        input load_en,
        input inc_en,
        input load_val,
        output ptr
    );
endinterface

// file: logic/ddpa_ptr_bank.sv
`include "ddpa_cfg.svh"

module ddpa_ptr_bank
(
    input wire logic pclk,
    input wire logic presetn,
    ddpa_ptr_if.bank pif
);

    genvar i;
    generate
        for (i = 0; i < 2; i++)
        begin : g_ptr
            // Only the selected pointer moves; the other holds
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pif.ptr[i] <= `DDPA_PTR_RST;
                end
                else if (pif.sel == 1'(i))
                begin
                    if (pif.load_en)
                    begin
                        pif.ptr[i] <= pif.load_val;
                    end
                    else if (pif.inc_en)
                    begin
                        pif.ptr[i] <= pif.ptr[i] + 16'h0001;
                    end
                end
            end
        end
    endgenerate

endmodule

// file: logic/ddpa_top.sv
// Behaviour
// - Two independent 16-bit external data pointers
// - Select bit zero picks pointer zero, else one
// - Boot enable maps boot memory F800h to FFFFh
// - User flag readable, writable, drives nothing
// - Bit two reads zero, ignores writes
// - Reset: select zero, boot enable from fuse
`include "ddpa_cfg.svh"

module ddpa_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic boot_jump_fuse,
    input wire logic [15:0] code_addr,
    output logic boot_map_enable,
    output logic boot_rom_hit,
    output logic pointer_select,
    output logic [15:0] xdata_addr
);

    ddpa_ptr_if pif ();

    ddpa_pkg::ddpa_init_type init_q;
    ddpa_pkg::ddpa_reg_type reg_sel;
    logic fuse_s1_q;
    logic fuse_s2_q;
    logic sel_q;
    logic flag_q;
    logic boot_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic boot_hit_q;
    logic [15:0] xaddr_q;
    logic access;
    logic answer;
    logic done;
    logic [7:0] aux_rd;
    logic [31:0] rd_mux;

    // Fuse pin synchroniser
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fuse_s1_q <= 1'b0;
            fuse_s2_q <= 1'b0;
        end
        else
        begin
            fuse_s1_q <= boot_jump_fuse;
            fuse_s2_q <= fuse_s1_q;
        end
    end

    // Start-up sequence: wait for synchroniser, then catch fuse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            init_q <= ddpa_pkg::INIT_SYNC1;
        end
        else
        begin
            unique case (init_q)
                ddpa_pkg::INIT_SYNC1: init_q <= ddpa_pkg::INIT_SYNC2;
                ddpa_pkg::INIT_SYNC2: init_q <= ddpa_pkg::INIT_LOAD;
                ddpa_pkg::INIT_LOAD: init_q <= ddpa_pkg::INIT_RUN;
                ddpa_pkg::INIT_RUN: init_q <= ddpa_pkg::INIT_RUN;
            endcase
        end
    end

    always_comb
    begin
        reg_sel = ddpa_pkg::REG_NONE;
        if (paddr[1:0] == 2'b00)
        begin
            unique case (paddr[11:2])
                `DDPA_AUX_IDX: reg_sel = ddpa_pkg::REG_AUX;
                `DDPA_PTR_IDX: reg_sel = ddpa_pkg::REG_PTR;
                `DDPA_INC_IDX: reg_sel = ddpa_pkg::REG_INC;
                `DDPA_DP0_IDX: reg_sel = ddpa_pkg::REG_DP0;
                `DDPA_DP1_IDX: reg_sel = ddpa_pkg::REG_DP1;
                default: reg_sel = ddpa_pkg::REG_NONE;
            endcase
        end
    end

    assign access = psel && penable;
    assign answer = access && !pready_q && (init_q == ddpa_pkg::INIT_RUN);
    assign done = access && pready_q;

    // Reserved bits and the stuck bit read as zero
    always_comb
    begin
        aux_rd = 8'h00;
        aux_rd[`DDPA_SEL_BIT] = sel_q;
        aux_rd[`DDPA_FLAG_BIT] = flag_q;
        aux_rd[`DDPA_BOOT_BIT] = boot_q;
        aux_rd[`DDPA_ZERO_BIT] = 1'b0;
    end

    always_comb
    begin
        unique case (reg_sel)
            ddpa_pkg::REG_AUX: rd_mux = {24'h000000, aux_rd};
            ddpa_pkg::REG_PTR: rd_mux = {16'h0000, pif.ptr[sel_q]};
            ddpa_pkg::REG_DP0: rd_mux = {16'h0000, pif.ptr[0]};
            ddpa_pkg::REG_DP1: rd_mux = {16'h0000, pif.ptr[1]};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // One wait state: ready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            pready_q <= answer;
            pslverr_q <= answer && (reg_sel == ddpa_pkg::REG_NONE);
            if (answer)
            begin
                prdata_q <= pwrite ? 32'h00000000 : rd_mux;
            end
        end
    end

    // Control register; writes land at the completing edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_q <= `DDPA_SEL_RST;
            flag_q <= `DDPA_FLAG_RST;
            boot_q <= `DDPA_BOOT_RST;
        end
        else if (init_q == ddpa_pkg::INIT_LOAD)
        begin
            boot_q <= fuse_s2_q;
        end
        else if (done && pwrite && reg_sel == ddpa_pkg::REG_AUX)
        begin
            sel_q <= pwdata[`DDPA_SEL_BIT];
            flag_q <= pwdata[`DDPA_FLAG_BIT];
            boot_q <= pwdata[`DDPA_BOOT_BIT];
        end
    end

    assign pif.sel = sel_q;
    assign pif.load_val = pwdata[15:0];
    assign pif.load_en = done && pwrite && (reg_sel == ddpa_pkg::REG_PTR);
    assign pif.inc_en = done && pwrite && (reg_sel == ddpa_pkg::REG_INC);

    ddpa_ptr_bank u_bank
    (
        .pclk(pclk),
        .presetn(presetn),
        .pif(pif)
    );

    // Registered outputs toward the memory interfaces
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xaddr_q <= `DDPA_PTR_RST;
            boot_hit_q <= 1'b0;
        end
        else
        begin
            xaddr_q <= pif.ptr[sel_q];
            boot_hit_q <= boot_q && (code_addr >= `DDPA_BOOT_BASE);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign boot_map_enable = boot_q;
    assign boot_rom_hit = boot_hit_q;
    assign pointer_select = sel_q;
    assign xdata_addr = xaddr_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_sel_route;
        ##1 xdata_addr == ($past(sel_q) ? $past(pif.ptr[1]) : $past(pif.ptr[0]));
    endproperty
    a_sel_route: assert property (p_sel_route) else $error("wrong pointer on address");

    property p_aux_write;
        done && pwrite && reg_sel == ddpa_pkg::REG_AUX && init_q == ddpa_pkg::INIT_RUN
        |=> pointer_select == $past(pwdata[`DDPA_SEL_BIT])
            && flag_q == $past(pwdata[`DDPA_FLAG_BIT])
            && boot_map_enable == $past(pwdata[`DDPA_BOOT_BIT]);
    endproperty
    a_aux_write: assert property (p_aux_write) else $error("aux write lost");

    property p_zero_bit;
        answer && !pwrite && reg_sel == ddpa_pkg::REG_AUX
        |=> pready && prdata[2] == 1'b0 && prdata[1] == 1'b0 && prdata[0] == $past(sel_q);
    endproperty
    a_zero_bit: assert property (p_zero_bit) else $error("stuck bit not zero");

    property p_fuse_load;
        init_q == ddpa_pkg::INIT_LOAD |=> boot_map_enable == $past(fuse_s2_q)
            ##1 boot_map_enable == $past(fuse_s2_q, 2);
    endproperty
    a_fuse_load: assert property (p_fuse_load) else $error("boot enable not from fuse");

    property p_sel_reset;
        init_q != ddpa_pkg::INIT_RUN |-> !pointer_select && !pready;
    endproperty
    a_sel_reset: assert property (p_sel_reset) else $error("select not zero after reset");

    property p_inc_only_sel;
        pif.inc_en && !sel_q |=> pif.ptr[0] == $past(pif.ptr[0]) + 16'h0001
            && $stable(pif.ptr[1]);
    endproperty
    a_inc_only_sel: assert property (p_inc_only_sel) else $error("inc moved wrong pointer");

    property p_load_only_sel;
        pif.load_en && sel_q |=> pif.ptr[1] == $past(pwdata[15:0]) && $stable(pif.ptr[0]);
    endproperty
    a_load_only_sel: assert property (p_load_only_sel) else $error("load hit wrong pointer");

    property p_boot_hit;
        ##1 boot_rom_hit == ($past(boot_q) && $past(code_addr) >= `DDPA_BOOT_BASE);
    endproperty
    a_boot_hit: assert property (p_boot_hit) else $error("boot window decode wrong");

    property p_ready_once;
        pready |=> !pready;
    endproperty
    a_ready_once: assert property (p_ready_once) else $error("ready longer than one cycle");

    property p_one_wait;
        psel && !penable ##1 access && init_q == ddpa_pkg::INIT_RUN |=> pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("ready not after one wait state");

    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

    property p_err_no_write;
        done && pwrite && reg_sel == ddpa_pkg::REG_NONE
        |=> $stable(sel_q) && $stable(flag_q) && $stable(boot_q);
    endproperty
    a_err_no_write: assert property (p_err_no_write) else $error("refused write changed state");

    property p_write_rdata;
        answer && pwrite |=> prdata == 32'h00000000;
    endproperty
    a_write_rdata: assert property (p_write_rdata) else $error("write answer carries data");

    property p_high_zero;
        pready |-> prdata[31:16] == 16'h0000;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("unused read bits not zero");

    property p_sel_hold;
        !(done && pwrite && reg_sel == ddpa_pkg::REG_AUX) |=> $stable(pointer_select);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select moved without write");

    property p_ptr_hold;
        !pif.load_en && !pif.inc_en |=> $stable(pif.ptr[0]) && $stable(pif.ptr[1]);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved without command");

    property p_inc_one_sel;
        pif.inc_en && sel_q |=> pif.ptr[1] == $past(pif.ptr[1]) + 16'h0001
            && $stable(pif.ptr[0]);
    endproperty
    a_inc_one_sel: assert property (p_inc_one_sel) else $error("inc moved wrong pointer");

    property p_load_zero_sel;
        pif.load_en && !sel_q |=> pif.ptr[0] == $past(pwdata[15:0]) && $stable(pif.ptr[1]);
    endproperty
    a_load_zero_sel: assert property (p_load_zero_sel) else $error("wrong pointer loaded");

    c_toggle: cover property (done && pwrite && reg_sel == ddpa_pkg::REG_AUX ##1 $changed(sel_q));
    c_inc_one: cover property (pif.inc_en && sel_q);
    c_boot_hit: cover property (boot_rom_hit);
    c_err: cover property (pslverr);
    c_fuse_boot: cover property (init_q == ddpa_pkg::INIT_LOAD ##1 boot_map_enable);

endmodule

// file: dv/ddpa_core_model.sv
`include "ddpa_cfg.svh"

module ddpa_core_model
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic [15:0] code_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        code_addr = 16'h0000;
    end

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        // Software keeps reserved aux bits clear
        pwdata <= (w && a == {`DDPA_AUX_IDX, 2'h0}) ? (d & 32'h0000_002D) : d;
        @(posedge pclk);
        penable <= 1'h1;
        // Waits for the answer; only the bench watchdog ends a hang
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        pwdata <= ~pwdata;
    endtask

    task automatic fetch(input logic [15:0] a);
        @(posedge pclk);
        code_addr <= a;
    endtask
endmodule

// file: dv/test_dual_data_pointer_aux_reg.sv
`include "ddpa_cfg.svh"

module test_dual_data_pointer_aux_reg;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] AUX = {`DDPA_AUX_IDX, 2'h0};
    localparam logic [11:0] PTR = {`DDPA_PTR_IDX, 2'h0};
    localparam logic [11:0] INC = {`DDPA_INC_IDX, 2'h0};
    localparam logic [11:0] DP0 = {`DDPA_DP0_IDX, 2'h0};
    localparam logic [11:0] DP1 = {`DDPA_DP1_IDX, 2'h0};

    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic fuse = 1'h1;
    logic psel, penable, pwrite, pready, pslverr, boot_map_enable, boot_rom_hit, pointer_select;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] code_addr, xdata_addr;
    int mismatches = 0;
    int n_tests = 0;

    always #10 pclk = ~pclk;

    ddpa_top dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .boot_jump_fuse(fuse), .code_addr(code_addr), .boot_map_enable(boot_map_enable),
        .boot_rom_hit(boot_rom_hit), .pointer_select(pointer_select), .xdata_addr(xdata_addr)
    );

    ddpa_core_model core
    (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .code_addr(code_addr)
    );

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One bus transfer; read data checked only on reads
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        core.xfer(w, a, d, r, e);
        if (!w)
        begin
            chk("prdata", x, r);
        end
        chk("pslverr", {31'h0, xe}, {31'h0, e});
    endtask

    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask

    task automatic final_report;
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #50000;
        mismatches++;
        final_report();
    end

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        repeat (4) @(posedge pclk);
        #1;
        chk("boot_map_enable", 32'h1, {31'h0, boot_map_enable});
        chk("pointer_select", 32'h0, {31'h0, pointer_select});
        acc(1'h0, AUX, 32'h0, 32'h0000_0020, 1'h0);
        acc(1'h1, AUX, 32'h0000_002D, 32'h0, 1'h0);
        acc(1'h0, AUX, 32'h0, 32'h0000_0029, 1'h0);
        settle();
        chk("pointer_select", 32'h1, {31'h0, pointer_select});
        // Increment of 29h toggles select, keeps flag
        acc(1'h1, AUX, 32'h0000_002A, 32'h0, 1'h0);
        acc(1'h0, AUX, 32'h0, 32'h0000_0028, 1'h0);
        acc(1'h1, PTR, 32'h0000_1234, 32'h0, 1'h0);
        acc(1'h1, AUX, 32'h0000_0021, 32'h0, 1'h0);
        acc(1'h1, PTR, 32'h0000_FFFF, 32'h0, 1'h0);
        acc(1'h1, INC, 32'h0, 32'h0, 1'h0);
        acc(1'h0, DP1, 32'h0, 32'h0, 1'h0);
        acc(1'h0, DP0, 32'h0, 32'h0000_1234, 1'h0);
        acc(1'h0, PTR, 32'h0, 32'h0, 1'h0);
        settle();
        chk("xdata_addr", 32'h0, {16'h0, xdata_addr});
        acc(1'h1, AUX, 32'h0000_0020, 32'h0, 1'h0);
        settle();
        chk("xdata_addr", 32'h1234, {16'h0, xdata_addr});
        acc(1'h1, INC, 32'h0, 32'h0, 1'h0);
        acc(1'h0, DP0, 32'h0, 32'h0000_1235, 1'h0);
        acc(1'h0, DP1, 32'h0, 32'h0, 1'h0);
        core.fetch(16'hF800);
        settle();
        chk("boot_rom_hit", 32'h1, {31'h0, boot_rom_hit});
        core.fetch(16'hF7FF);
        settle();
        chk("boot_rom_hit", 32'h0, {31'h0, boot_rom_hit});
        acc(1'h1, AUX, 32'h0, 32'h0, 1'h0);
        core.fetch(16'hFFFF);
        settle();
        chk("boot_rom_hit", 32'h0, {31'h0, boot_rom_hit});
        chk("boot_map_enable", 32'h0, {31'h0, boot_map_enable});
        acc(1'h0, 12'h2A0, 32'h0, 32'h0, 1'h1);
        acc(1'h1, 12'h289, 32'h0000_0021, 32'h0, 1'h1);
        acc(1'h0, AUX, 32'h0, 32'h0, 1'h0);
        // Second reset with the fuse low
        @(posedge pclk);
        presetn <= 1'h0;
        fuse <= 1'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        repeat (4) @(posedge pclk);
        #1;
        chk("boot_map_enable", 32'h0, {31'h0, boot_map_enable});
        acc(1'h0, AUX, 32'h0, 32'h0, 1'h0);
        acc(1'h0, DP0, 32'h0, 32'h0, 1'h0);
        final_report();
    end
endmodule
